/* File: bol_loader.sv */
`default_nettype none
module bol_loader (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // reset events
  input wire logic por_event,
  input wire logic vlls_wake_event,
  input wire logic sys_reset_event,
  // option byte read from flash
  output logic opt_req,
  input wire logic opt_valid,
  input wire logic [7:0] opt_data,
  // configuration outputs
  output logic load_busy,
  output logic flash_init_fast,
  output logic [2:0] core_clock_divider,
  output logic slow_clock_select,
  // reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic reset_pin_enable,
  output logic reset_pin_pullup,
  output logic reset_pin_filter,
  output logic reset_pin_wakeup,
  // nonmaskable interrupt pin
  input wire logic nmi_pin_in,
  output logic nmi_pin_pullup,
  output logic nmi_irq,
  output logic nmi_wakeup,
  // debug access port and security
  input wire logic flash_secure,
  input wire logic dbg_mass_erase_req,
  input wire logic dbg_sys_reset_req,
  output logic mass_erase_grant,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  bol_pkg::bol_state_t state_reg, state_next;
  logic [7:0] boot_option_config_reg, boot_option_config_next;
  logic por_load_reg, por_load_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [1:0] rst_sync_reg, rst_sync_next;
  logic [1:0] nmi_sync_reg, nmi_sync_next;
  logic load_busy_next, opt_req_next;
  logic fast_next, slow_next, rst_en_next, rst_oe_next;
  logic rst_wake_next, nmi_irq_next, nmi_wake_next, erase_next;
  logic [2:0] div_next;
  logic [1:0] div_sel;
  logic [7:0] opt_clean;
  logic any_event;

  assign any_event = por_event | vlls_wake_event | sys_reset_event;
  // reserved bits carry nothing but still read as erased ones
  assign opt_clean = opt_data | bol_pkg::BOL_RESERVED_MASK;

  // loader state
  always_comb begin
    state_next = state_reg;
    boot_option_config_next = boot_option_config_reg;
    por_load_next = por_load_reg;
    unique case (state_reg)
      bol_pkg::BOL_ST_LOAD: begin
        if (opt_valid) begin
          // reset pin select only follows the byte after a power-on event or resetn
          boot_option_config_next = opt_clean;
          if (!por_load_reg) begin
            boot_option_config_next[bol_pkg::BOL_BIT_RSTPIN_SEL] =
              boot_option_config_reg[bol_pkg::BOL_BIT_RSTPIN_SEL];
          end
          por_load_next = 1'b0;
          state_next = bol_pkg::BOL_ST_RUN;
        end
      end
      bol_pkg::BOL_ST_RUN: begin
        // only reset events reload, never software
        if (any_event) begin
          state_next = bol_pkg::BOL_ST_LOAD;
          por_load_next = por_event;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= bol_pkg::BOL_ST_LOAD;
      boot_option_config_reg <= bol_pkg::BOL_ERASED_VALUE;
      por_load_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      boot_option_config_reg <= boot_option_config_next;
      por_load_reg <= por_load_next;
    end
  end

  // derived configuration, registered from the next register value
  assign div_sel = {boot_option_config_next[bol_pkg::BOL_BIT_CLKDIV_HI],
                    boot_option_config_next[bol_pkg::BOL_BIT_CLKDIV_LO]};

  always_comb begin
    unique case (div_sel)
      2'h0: div_next = bol_pkg::BOL_DIV_BY8;
      2'h1: div_next = bol_pkg::BOL_DIV_BY4;
      2'h2: div_next = bol_pkg::BOL_DIV_BY2;
      2'h3: div_next = bol_pkg::BOL_DIV_BY1;
    endcase
    slow_next = (div_sel != 2'h3);
    // zero means slow init paced by the divider above
    fast_next = boot_option_config_next[bol_pkg::BOL_BIT_QUICK_INIT];
    load_busy_next = (state_next == bol_pkg::BOL_ST_LOAD);
    opt_req_next = load_busy_next & ~opt_valid;
    rst_en_next =
      boot_option_config_next[bol_pkg::BOL_BIT_RSTPIN_SEL];
    // pin held low only while a power-on load is pending
    rst_oe_next = load_busy_next & por_load_next;
    rst_wake_next = rst_en_next & ctrl_next[bol_pkg::BOL_CTL_RSTPIN_WAKE] &
                    ~rst_sync_reg[1];
    nmi_irq_next = boot_option_config_next[bol_pkg::BOL_BIT_NMI_SEL] &
                   ~nmi_sync_reg[1];
    nmi_wake_next = nmi_irq_next & ctrl_next[bol_pkg::BOL_CTL_NMI_WAKE];
    if (!rst_en_next && flash_secure) begin
      erase_next = dbg_mass_erase_req & dbg_sys_reset_req;
    end else begin
      erase_next = dbg_mass_erase_req;
    end
  end

  // pin synchronisers, first stage read only by the second
  assign rst_sync_next = {rst_sync_reg[0], reset_pin_in};
  assign nmi_sync_next = {nmi_sync_reg[0], nmi_pin_in};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h3;
      nmi_sync_reg <= 2'h3;
      load_busy <= 1'b1;
      opt_req <= 1'b0;
      flash_init_fast <= 1'b1;
      core_clock_divider <= bol_pkg::BOL_DIV_BY1;
      slow_clock_select <= 1'b0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      reset_pin_enable <= 1'b1;
      reset_pin_pullup <= 1'b1;
      reset_pin_filter <= 1'b1;
      reset_pin_wakeup <= 1'b0;
      nmi_pin_pullup <= 1'b1;
      nmi_irq <= 1'b0;
      nmi_wakeup <= 1'b0;
      mass_erase_grant <= 1'b0;
    end else begin
      rst_sync_reg <= rst_sync_next;
      nmi_sync_reg <= nmi_sync_next;
      load_busy <= load_busy_next;
      opt_req <= opt_req_next;
      flash_init_fast <= fast_next;
      core_clock_divider <= div_next;
      slow_clock_select <= slow_next;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= rst_oe_next;
      reset_pin_enable <= rst_en_next;
      reset_pin_pullup <= rst_en_next;
      reset_pin_filter <= rst_en_next;
      reset_pin_wakeup <= rst_wake_next;
      // pull-up stays on whatever the nmi select says
      nmi_pin_pullup <= 1'b1;
      nmi_irq <= nmi_irq_next;
      nmi_wakeup <= nmi_wake_next;
      mass_erase_grant <= erase_next;
    end
  end

  // axi4-lite slave; address and data may arrive in either order
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [3:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    ctrl_next = ctrl_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = bol_pkg::BOL_RESP_OKAY;
      unique case (aw_addr_reg)
        // writes to the option register are dropped
        bol_pkg::BOL_ADDR_CONFIG: ;
        bol_pkg::BOL_ADDR_STATUS: ;
        bol_pkg::BOL_ADDR_CONTROL: begin
          if (w_strb_reg[0]) begin
            ctrl_next = w_data_reg[1:0];
          end
        end
        default: bresp_next = bol_pkg::BOL_RESP_DECERR;
      endcase
    end
    awready_next = ~aw_have_next;
    wready_next = ~w_have_next;
  end

  always_comb begin
    rvalid_next = s_axi_rvalid;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = bol_pkg::BOL_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr)
        bol_pkg::BOL_ADDR_CONFIG: begin
          rdata_next[7:0] = boot_option_config_reg;
        end
        bol_pkg::BOL_ADDR_STATUS: rdata_next[0] = load_busy;
        bol_pkg::BOL_ADDR_CONTROL: rdata_next[1:0] = ctrl_reg;
        default: rresp_next = bol_pkg::BOL_RESP_DECERR;
      endcase
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= bol_pkg::BOL_CTL_RESET;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bol_pkg::BOL_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bol_pkg::BOL_RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      ctrl_reg <= ctrl_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
  end

endmodule : bol_loader
`default_nettype wire

/* File: bol_pkg.sv */
`default_nettype none
package bol_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // register byte addresses
  localparam logic [3:0] BOL_ADDR_CONFIG = 4'h0;
  localparam logic [3:0] BOL_ADDR_STATUS = 4'h4;
  localparam logic [3:0] BOL_ADDR_CONTROL = 4'h8;
  // field positions in boot_option_config
  localparam int BOL_BIT_CLKDIV_LO = 0;
  localparam int BOL_BIT_NMI_SEL = 2;
  localparam int BOL_BIT_RSTPIN_SEL = 3;
  localparam int BOL_BIT_CLKDIV_HI = 4;
  localparam int BOL_BIT_QUICK_INIT = 5;
  localparam logic [7:0] BOL_RESERVED_MASK = 8'hc0;
  // erased flash reads all ones
  localparam logic [7:0] BOL_ERASED_VALUE = 8'hff;
  // control register fields
  localparam int BOL_CTL_RSTPIN_WAKE = 0;
  localparam int BOL_CTL_NMI_WAKE = 1;
  localparam logic [1:0] BOL_CTL_RESET = 2'h0;
  // core clock divider reset values per boot clock divider select
  localparam logic [2:0] BOL_DIV_BY8 = 3'h7;
  localparam logic [2:0] BOL_DIV_BY4 = 3'h3;
  localparam logic [2:0] BOL_DIV_BY2 = 3'h1;
  localparam logic [2:0] BOL_DIV_BY1 = 3'h0;
  // axi responses
  localparam logic [1:0] BOL_RESP_OKAY = 2'h0;
  localparam logic [1:0] BOL_RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    BOL_ST_LOAD = 2'b00,
    BOL_ST_RUN = 2'b01
  } bol_state_t;
endpackage : bol_pkg
`default_nettype wire

/* File: bol_pkg_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* File: bol_opt_flash.sv */
`default_nettype none
module bol_opt_flash (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // request and stored byte
  input wire logic opt_req,
  input wire logic [7:0] prog_byte,
  input wire logic [3:0] delay,
  // answer
  output logic opt_valid,
  output logic [7:0] opt_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    opt_valid = 1'b0;
    opt_data = 8'h00;
    cnt = 0;
  end
  // bus not held between answers, so a stale byte cannot pass
  always @(posedge clk) begin
    if (resetn && opt_req && !opt_valid && cnt == delay) begin
      opt_valid <= 1'b1;
      opt_data <= prog_byte;
    end else begin
      opt_valid <= 1'b0;
      opt_data <= ~opt_data;
    end
    if (!resetn || !opt_req || opt_valid) begin
      cnt <= 0;
    end else if (cnt != delay) begin
      cnt <= cnt + 1;
    end
  end
endmodule : bol_opt_flash
`default_nettype wire

/* File: bol_loader_props.sv */
`default_nettype none
module bol_loader_props (
  // watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic opt_valid,
  input wire logic [7:0] opt_data,
  input wire logic load_busy,
  input wire logic flash_init_fast,
  input wire logic [2:0] core_clock_divider,
  input wire logic slow_clock_select,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_enable,
  input wire logic reset_pin_filter,
  input wire logic reset_pin_wakeup,
  input wire logic nmi_irq,
  input wire logic nmi_wakeup,
  input wire logic flash_secure,
  input wire logic dbg_mass_erase_req,
  input wire logic dbg_sys_reset_req,
  input wire logic mass_erase_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic nmi_sel_reg;
  logic nmi_sel_next;
  assign take = opt_valid && load_busy;
  always_comb begin
    nmi_sel_next = take ? opt_data[2] : nmi_sel_reg;
  end
  always_ff @(posedge clk) begin
    nmi_sel_reg <= !resetn ? 1'b1 : nmi_sel_next;
  end
  AST_LOAD_END: assert property (take |=> !load_busy)
    else $error("load did not end");
  AST_FAST: assert property (
    take |=> flash_init_fast == $past(opt_data[5]))
    else $error("fast init bit wrong");
  AST_DIV: assert property (take |=> core_clock_divider ==
    3'((8 >> $past({opt_data[4], opt_data[0]})) - 1))
    else $error("core divider wrong");
  AST_SLOW: assert property (
    slow_clock_select == (core_clock_divider != 3'h0))
    else $error("slow clock select wrong");
  AST_HOLD: assert property (!load_busy |=>
    $stable(flash_init_fast) && $stable(core_clock_divider))
    else $error("config moved outside load");
  AST_PIN: assert property (reset_pin_filter == reset_pin_enable)
    else $error("reset pin filter mismatch");
  AST_OE: assert property ($fell(reset_pin_oe) |-> $past(take))
    else $error("reset pin released early");
  AST_RWAKE: assert property (reset_pin_wakeup |-> reset_pin_enable)
    else $error("disabled reset pin woke");
  AST_NMI: assert property (
    !nmi_sel_reg |-> !nmi_irq && !nmi_wakeup)
    else $error("blocked nmi seen");
  AST_ERASE: assert property (!load_busy && !reset_pin_enable &&
    flash_secure && dbg_mass_erase_req && !dbg_sys_reset_req
    |=> !mass_erase_grant)
    else $error("erase granted without reset request");
  cover property (take && !opt_data[3]);
  cover property (mass_erase_grant && !reset_pin_enable);
  cover property (nmi_wakeup);
endmodule : bol_loader_props
bind bol_loader bol_loader_props u_props (.clk(clk), .resetn(resetn),
  .opt_valid(opt_valid), .opt_data(opt_data), .load_busy(load_busy),
  .flash_init_fast(flash_init_fast),
  .core_clock_divider(core_clock_divider),
  .slow_clock_select(slow_clock_select), .reset_pin_oe(reset_pin_oe),
  .reset_pin_enable(reset_pin_enable), .reset_pin_filter(reset_pin_filter),
  .reset_pin_wakeup(reset_pin_wakeup), .nmi_irq(nmi_irq),
  .nmi_wakeup(nmi_wakeup), .flash_secure(flash_secure),
  .dbg_mass_erase_req(dbg_mass_erase_req),
  .dbg_sys_reset_req(dbg_sys_reset_req),
  .mass_erase_grant(mass_erase_grant));
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, por_event, vlls_wake_event, sys_reset_event;
  logic opt_req, opt_valid, load_busy, flash_init_fast, slow_clock_select;
  logic [7:0] opt_data, prog_byte, exp_cfg;
  logic [2:0] core_clock_divider;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, reset_pin_enable;
  logic reset_pin_pullup, reset_pin_filter, reset_pin_wakeup, exp_rst;
  logic nmi_pin_in, nmi_pin_pullup, nmi_irq, nmi_wakeup, flash_secure;
  logic dbg_mass_erase_req, dbg_sys_reset_req, mass_erase_grant;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int n_mismatch, check_count;
  bol_loader DUT (.clk(clk), .resetn(resetn), .por_event(por_event),
    .vlls_wake_event(vlls_wake_event), .sys_reset_event(sys_reset_event),
    .opt_req(opt_req), .opt_valid(opt_valid), .opt_data(opt_data),
    .load_busy(load_busy), .flash_init_fast(flash_init_fast),
    .core_clock_divider(core_clock_divider),
    .slow_clock_select(slow_clock_select), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .reset_pin_enable(reset_pin_enable), .reset_pin_pullup(reset_pin_pullup),
    .reset_pin_filter(reset_pin_filter), .reset_pin_wakeup(reset_pin_wakeup),
    .nmi_pin_in(nmi_pin_in), .nmi_pin_pullup(nmi_pin_pullup),
    .nmi_irq(nmi_irq), .nmi_wakeup(nmi_wakeup), .flash_secure(flash_secure),
    .dbg_mass_erase_req(dbg_mass_erase_req),
    .dbg_sys_reset_req(dbg_sys_reset_req),
    .mass_erase_grant(mass_erase_grant), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  bol_opt_flash u_flash (.clk(clk), .resetn(resetn), .opt_req(opt_req),
    .prog_byte(prog_byte), .delay(rnd[3:0]), .opt_valid(opt_valid),
    .opt_data(opt_data));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // kind: 0 power-on event, 1 stop recovery, 2 system reset, 3 resetn
  task automatic reload(input int kind);
    int exp_div;
    @(posedge clk);
    resetn <= kind != 3;
    por_event <= kind == 0;
    vlls_wake_event <= kind == 1;
    sys_reset_event <= kind == 2;
    repeat (kind == 3 ? 10 : 1) @(posedge clk);
    {resetn, por_event, vlls_wake_event, sys_reset_event} <= 4'b1000;
    @(posedge clk);
    chk("oe_load", kind == 0 || kind == 3, reset_pin_oe);
    while (load_busy) @(posedge clk);
    if (kind == 0 || kind == 3) exp_rst = prog_byte[3];
    exp_cfg = {2'b11, prog_byte[5:4], exp_rst, prog_byte[2:0]};
    exp_div = (8 >> {prog_byte[4], prog_byte[0]}) - 1;
    chk("oe_done", 1'b0, reset_pin_oe);
    chk("pin_out", 1'b0, reset_pin_out);
    chk("opt_req", 1'b0, opt_req);
    axr(4'h0, rd, resp);
    chk("config", {24'h0, exp_cfg}, rd);
    chk("divider", exp_div, core_clock_divider);
    chk("fast", prog_byte[5], flash_init_fast);
    chk("slow", exp_div != 0, slow_clock_select);
    chk("pin_en", exp_rst, reset_pin_enable);
    chk("pin_pu", exp_rst, reset_pin_pullup);
    chk("pin_flt", exp_rst, reset_pin_filter);
  endtask : reload
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {resetn, por_event, vlls_wake_event, sys_reset_event} = 4'b0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, flash_secure} = 3'b000;
    {reset_pin_in, nmi_pin_in} = 2'b11;
    {dbg_mass_erase_req, dbg_sys_reset_req} = 2'b00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rnd = 32'h492f;
    prog_byte = 8'hff;
    reload(3);
    axw(4'h0, 32'h0, resp);
    chk("wr_resp", 2'h0, resp);
    axr(4'hc, rd, resp);
    chk("unmapped", 2'h3, resp);
    axr(4'h4, rd, resp);
    chk("status", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      prog_byte <= {rnd[7:5], i[1], i[2] ^ i[0], rnd[2:1], i[0]};
      axr(4'h0, rd, resp);
      chk("unchanged", {24'h0, exp_cfg}, rd);
      reload(i % 4);
      axw(4'h8, 32'h3, resp);
      chk("ctl_resp", 2'h0, resp);
      axr(4'h8, rd, resp);
      chk("control", 32'h3, rd);
      nmi_pin_in <= 1'b0;
      reset_pin_in <= 1'b0;
      flash_secure <= 1'b1;
      dbg_mass_erase_req <= 1'b1;
      dbg_sys_reset_req <= i[0];
      repeat (5) @(posedge clk);
      chk("nmi", prog_byte[2], nmi_irq);
      chk("nmi_wake", prog_byte[2], nmi_wakeup);
      chk("nmi_pullup", 1'b1, nmi_pin_pullup);
      chk("rst_wake", exp_rst, reset_pin_wakeup);
      chk("erase", exp_rst | i[0], mass_erase_grant);
      {nmi_pin_in, reset_pin_in, dbg_mass_erase_req} <= 3'b110;
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
